/* File: rtl/vec_alu.v */
// vector subtract, saturating subtract, shuffle and exclusive-or datapath
// assumes the issue stage supplies register contents and a one-cycle
// issue strobe; the result returns one cycle later to the register file
// How it works
// - zero-extend both operands, subtract, then clamp to signed range
// - clamp to max positive or most negative, else pass through
// - plain subtract wraps modulo lane width, never saturates
// - lanes of 8/16/32/64 bits, length over lane width in parallel
// - 5-bit unsigned immediate zero-extended and subtracted per lane
// - register subtract decoded from major, operation and minor fields
// - immediate subtract decoded with immediate in second source field
// - shuffle picks from first source above second source
// - shuffle index: low six bits modulo element count of the pair
// - control bit 6 or 7 set writes zero to that element
// - vector exclusive-or over every bit of both sources
// - byte immediate exclusive-or applied to every byte lane
// - no exception ever depends on operand values
// - extension absent or disabled raises exception, no execution
`timescale 1ns/1ns
`default_nettype none
`include "vec_alu_map.vh"
module vec_alu #(
  parameter VLEN = 128
) (
  // clock and reset
  input wire core_clk,
  input wire reset,
  // issue side
  input wire issue_valid,
  input wire [31:0] instr,
  input wire ext_present,
  input wire ext_enabled,
  input wire [VLEN-1:0] first_source_vector_reg,
  input wire [VLEN-1:0] second_source_vector_reg,
  input wire [VLEN-1:0] dest_vector_reg,
  // result side
  output reg result_valid,
  output reg [4:0] result_index,
  output reg [VLEN-1:0] result_data,
  output reg reserved_instr_exc,
  output reg ext_disabled_exc
);

  // ****************************************************************
  // decode
  // ****************************************************************
  wire [5:0] major = instr[31:26];
  wire [2:0] opf = instr[25:23];
  wire [1:0] element_format = instr[22:21];
  wire [4:0] unsigned_imm_five = instr[20:16];
  wire [7:0] byte_immediate = instr[23:16];
  wire [5:0] minor = instr[5:0];

  // ****************************************************************
  // instruction match
  // ****************************************************************
  // all matches share the one major group; operation and minor fields
  // keep them apart, so at most one is ever true
  wire in_group = (major == `MAJOR_OP);
  wire is_sub = in_group && (opf == `OPF_SUB) && (minor == `MINOR_3R_SUB);
  wire is_subi = in_group && (opf == `OPF_SUB) && (minor == `MINOR_I5_SUB);
  wire is_sat = in_group && (opf == `OPF_SUBSUU) &&
    (minor == `MINOR_3R_SAT);
  wire is_shf = in_group && (opf == `OPF_SHF) && (minor == `MINOR_3R_SHF);
  wire is_xor = in_group && (instr[25:21] == `OPF_XOR_V) &&
    (minor == `MINOR_VEC);
  wire is_xori = in_group && (instr[25:24] == `MAJOR_XORI) &&
    (minor == `MINOR_BYTE_IMM);

  reg [2:0] kind;
  always @* begin
    if (is_sub) begin
      kind = `KIND_SUB;
    end else if (is_subi) begin
      kind = `KIND_SUBI;
    end else if (is_sat) begin
      kind = `KIND_SAT;
    end else if (is_shf) begin
      kind = `KIND_SHF;
    end else if (is_xor) begin
      kind = `KIND_XOR;
    end else if (is_xori) begin
      kind = `KIND_XORI;
    end else begin
      kind = `KIND_NONE;
    end
  end

  // ****************************************************************
  // per-lane arithmetic
  // ****************************************************************
  // byte, half, word, double results computed side by side; the
  // format mux picks one, trading area for a single-cycle result
  wire [VLEN-1:0] sub_b, sub_h, sub_w, sub_d;
  wire [VLEN-1:0] sat_b, sat_h, sat_w, sat_d;
  wire [VLEN-1:0] shf_b, shf_h, shf_w, shf_d;
  wire [VLEN-1:0] sub_rhs_b, sub_rhs_h, sub_rhs_w, sub_rhs_d;

  // ****************************************************************
  // immediate widening
  // ****************************************************************
  // the five-bit immediate is zero-filled to each lane width, so the
  // lane subtract takes one right-hand operand for register and immediate forms
  wire use_imm = (kind == `KIND_SUBI);
  genvar gi;
  // lane counts follow vector length over lane width
  generate
    for (gi = 0; gi < VLEN/8; gi = gi + 1) begin : g_b
      assign sub_rhs_b[8*gi+7:8*gi] = use_imm ?
        {3'h0, unsigned_imm_five} : second_source_vector_reg[8*gi+7:8*gi];
    end

    for (gi = 0; gi < VLEN/16; gi = gi + 1) begin : g_h
      assign sub_rhs_h[16*gi+15:16*gi] = use_imm ?
        {{11{1'b0}}, unsigned_imm_five} :
        second_source_vector_reg[16*gi+15:16*gi];
    end

    for (gi = 0; gi < VLEN/32; gi = gi + 1) begin : g_w
      assign sub_rhs_w[32*gi+31:32*gi] = use_imm ?
        {{27{1'b0}}, unsigned_imm_five} :
        second_source_vector_reg[32*gi+31:32*gi];
    end

    for (gi = 0; gi < VLEN/64; gi = gi + 1) begin : g_d
      assign sub_rhs_d[64*gi+63:64*gi] = use_imm ?
        {{59{1'b0}}, unsigned_imm_five} :
        second_source_vector_reg[64*gi+63:64*gi];
    end
  endgenerate

  // ****************************************************************
  // lane engines
  // ****************************************************************
  // byte lanes
  vec_lanes #(.VLEN(VLEN), .W(8)) u_b (
    .src_a(first_source_vector_reg),
    .src_b(second_source_vector_reg),
    .sub_rhs(sub_rhs_b),
    .ctrl(dest_vector_reg),
    .diff(sub_b),
    .sat(sat_b),
    .shf(shf_b)
  );

  // halfword lanes
  vec_lanes #(.VLEN(VLEN), .W(16)) u_h (
    .src_a(first_source_vector_reg),
    .src_b(second_source_vector_reg),
    .sub_rhs(sub_rhs_h),
    .ctrl(dest_vector_reg),
    .diff(sub_h),
    .sat(sat_h),
    .shf(shf_h)
  );

  // word lanes
  vec_lanes #(.VLEN(VLEN), .W(32)) u_w (
    .src_a(first_source_vector_reg),
    .src_b(second_source_vector_reg),
    .sub_rhs(sub_rhs_w),
    .ctrl(dest_vector_reg),
    .diff(sub_w),
    .sat(sat_w),
    .shf(shf_w)
  );

  // doubleword lanes
  vec_lanes #(.VLEN(VLEN), .W(64)) u_d (
    .src_a(first_source_vector_reg),
    .src_b(second_source_vector_reg),
    .sub_rhs(sub_rhs_d),
    .ctrl(dest_vector_reg),
    .diff(sub_d),
    .sat(sat_d),
    .shf(shf_d)
  );

  // ****************************************************************
  // result select
  // ****************************************************************
  // an op that is not known yields zeros and is never written back
  reg [VLEN-1:0] result_d;
  always @* begin
    case (kind)
      `KIND_SUB, `KIND_SUBI: begin
        case (element_format)
          `FMT_B: result_d = sub_b;
          `FMT_H: result_d = sub_h;
          `FMT_W: result_d = sub_w;
          default: result_d = sub_d;
        endcase
      end
      `KIND_SAT: begin
        case (element_format)
          `FMT_B: result_d = sat_b;
          `FMT_H: result_d = sat_h;
          `FMT_W: result_d = sat_w;
          default: result_d = sat_d;
        endcase
      end
      `KIND_SHF: begin
        case (element_format)
          `FMT_B: result_d = shf_b;
          `FMT_H: result_d = shf_h;
          `FMT_W: result_d = shf_w;
          default: result_d = shf_d;
        endcase
      end
      `KIND_XOR: result_d = first_source_vector_reg ^
        second_source_vector_reg;
      `KIND_XORI: result_d = first_source_vector_reg ^
        {(VLEN/8){byte_immediate}};
      default: result_d = {VLEN{1'b0}};
    endcase
  end

  // ****************************************************************
  // answer pulses
  // ****************************************************************
  // operand values never reach the exception logic
  // absent or unknown outranks disabled, so one pulse per issue
  wire known = (kind != `KIND_NONE);
  wire go = issue_valid && known && ext_present && ext_enabled;
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      result_valid <= 1'b0;
      reserved_instr_exc <= 1'b0;
      ext_disabled_exc <= 1'b0;
    end else begin
      result_valid <= go;
      reserved_instr_exc <= issue_valid && (!known || !ext_present);
      ext_disabled_exc <= issue_valid && known && ext_present &&
        !ext_enabled;
    end
  end

  // ****************************************************************
  // result hold
  // ****************************************************************
  // index and data move only on an accepted op; a refused one leaves
  // the last write standing
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      result_index <= 5'h00;
      result_data <= {VLEN{1'b0}};
    end else if (go) begin
      result_index <= instr[10:6];
      result_data <= result_d;
    end
  end
endmodule

// lane engine for one element width; all lanes see the original
// control vector, so no lane's write can disturb another's pick
module vec_lanes #(
  parameter VLEN = 128,
  parameter W = 8
) (
  // operands
  input wire [VLEN-1:0] src_a,
  input wire [VLEN-1:0] src_b,
  input wire [VLEN-1:0] sub_rhs,
  input wire [VLEN-1:0] ctrl,
  // lane results
  output wire [VLEN-1:0] diff,
  output wire [VLEN-1:0] sat,
  output wire [VLEN-1:0] shf
);
  localparam N = VLEN / W;
  localparam NN = 2 * N;

  // ****************************************************************
  // operand pair
  // ****************************************************************
  // first source is the upper half, so its lane 0 is element N
  wire [2*VLEN-1:0] pair = {src_a, src_b};

  // ****************************************************************
  // lanes
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_lane
      wire [W-1:0] a = src_a[W*i+W-1:W*i];
      wire [W-1:0] b = src_b[W*i+W-1:W*i];

      // wraps modulo lane width
      assign diff[W*i+W-1:W*i] = a - sub_rhs[W*i+W-1:W*i];

      // one extra bit holds the true difference of two unsigned lanes
      wire [W:0] t = {1'b0, a} - {1'b0, b};
      wire hi_ok = (t[W] == t[W-1]);
      // clamp when the top two bits disagree
      assign sat[W*i+W-1:W*i] = hi_ok ? t[W-1:0] :
        (t[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}});

      // control taken from the pre-write copy
      // the modulus folds any six-bit index back into the pair
      wire [5:0] sel6 = ctrl[W*i+5:W*i];
      wire [31:0] k = {{26{1'b0}}, sel6} % NN;
      wire [W-1:0] pick = pair[W*k +: W];
      assign shf[W*i+W-1:W*i] = (ctrl[W*i+7:W*i+6] != 2'h0) ?
        {W{1'b0}} : pick;
    end
  endgenerate
endmodule
`default_nettype wire

/* File: rtl/vec_alu_map.vh */
// constants for the vector subtract, shuffle and exclusive-or datapath
// assumes inclusion by the datapath module, the bench and the port checker
`ifndef VEC_ALU_MAP_VH
`define VEC_ALU_MAP_VH
`define MAJOR_OP 6'h1E
`define MINOR_3R_SUB 6'h0E
`define MINOR_I5_SUB 6'h06
`define OPF_SUB 3'h1
`define OPF_SUBSUU 3'h2
`define MINOR_3R_SAT 6'h11
`define OPF_SHF 3'h0
`define MINOR_3R_SHF 6'h15
`define MINOR_VEC 6'h1E
`define OPF_XOR_V 5'h03
`define MAJOR_XORI 2'h3
`define MINOR_BYTE_IMM 6'h00
`define FMT_B 2'h0
`define FMT_H 2'h1
`define FMT_W 2'h2
`define FMT_D 2'h3
`define KIND_NONE 3'h0
`define KIND_SUB 3'h1
`define KIND_SUBI 3'h2
`define KIND_SAT 3'h3
`define KIND_SHF 3'h4
`define KIND_XOR 3'h5
`define KIND_XORI 3'h6
`endif

/* File: test/test_vector_subtract_shuffle_xor_alu.sv */
// self-checking bench for the vector datapath
// assumes VLEN of 128 and a one-cycle answer
`timescale 1ns/1ns
`default_nettype none
`include "vec_alu_map.vh"
module test_vector_subtract_shuffle_xor_alu;
  // ****************
  // bench
  // ****************
  logic core_clk = 0, reset = 1, issue_valid = 0;
  logic ext_present = 1, ext_enabled = 1;
  logic [31:0] instr = 0;
  logic [127:0] a = 128'hF0E1D2C3B4A5968778695A4B3C2D1E0F;
  logic [127:0] b = 128'h0100000180000002FF010000FE355679;
  logic [127:0] d = 128'h254080C53F1F1000010203040506C708;
  wire logic result_valid, reserved_instr_exc, ext_disabled_exc;
  wire logic [4:0] result_index;
  wire logic [127:0] result_data, rf_data;
  int mismatches = 0, n_compared = 0;
  vec_alu i_dut (.core_clk(core_clk), .reset(reset),
    .issue_valid(issue_valid), .instr(instr), .ext_present(ext_present),
    .ext_enabled(ext_enabled), .first_source_vector_reg(a),
    .second_source_vector_reg(b), .dest_vector_reg(d),
    .result_valid(result_valid), .result_index(result_index),
    .result_data(result_data), .reserved_instr_exc(reserved_instr_exc),
    .ext_disabled_exc(ext_disabled_exc));
  vreg_file i_rf (.core_clk(core_clk), .wr_en(result_valid),
    .wr_index(result_index), .wr_data(result_data), .rd_index(5'h03),
    .rd_data(rf_data));
  initial forever #5 core_clk = ~core_clk;
  task chk_data(input logic [127:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: data %h", $time, got);
    end
  endtask
  task chk_flags(input logic [2:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: flags %b", $time, got);
    end
  endtask
  // inputs move on the falling edge, so no race with the taking edge
  task issue(input logic [31:0] op, input logic [2:0] fl);
    @(negedge core_clk);
    instr = op;
    issue_valid = 1;
    @(negedge core_clk);
    issue_valid = 0;
    chk_flags({result_valid, reserved_instr_exc, ext_disabled_exc}, fl);
  endtask
  function logic [31:0] r3(input logic [4:0] f, input logic [5:0] m);
    return {`MAJOR_OP, f, 5'h1F, 5'h02, 5'h03, m};
  endfunction
  // borrow chain cut at each lane edge; y lane gets imm when imm_mode
  function logic [127:0] exp_sub(input logic [127:0] x, y,
      input logic [1:0] f, input logic imm_mode);
    logic [8:0] t;
    logic c;
    c = 0;
    for (int j = 0; j < 16; j++) begin
      if (imm_mode) y[8*j +: 8] = (j % (1 << f) == 0) ? 8'h1F : 8'h00;
      t = {1'b0, x[8*j +: 8]} - {1'b0, y[8*j +: 8]} - c;
      exp_sub[8*j +: 8] = t[7:0];
      c = ((j + 1) % (1 << f) == 0) ? 1'b0 : t[8];
    end
  endfunction
  function logic [127:0] exp_shf(input logic [1:0] f);
    int n, k;
    logic [255:0] v;
    v = {a, b};
    n = 1 << f;
    exp_shf = 0;
    for (int i = 0; i < 16 / n; i++) begin
      k = d[8*n*i +: 6] % (32 / n);
      for (int m = 0; m < n; m++)
        if (d[8*n*i+6 +: 2] == 0)
          exp_shf[8*(n*i+m) +: 8] = v[8*(n*k+m) +: 8];
    end
  endfunction
  task t_sub_all;
    for (int f = 0; f < 4; f++) begin
      issue(r3({`OPF_SUB, 2'(f)}, `MINOR_3R_SUB), 3'h4);
      chk_data(result_data, exp_sub(a, b, 2'(f), 0));
      issue(r3({`OPF_SUB, 2'(f)}, `MINOR_I5_SUB), 3'h4);
      chk_data(result_data, exp_sub(a, b, 2'(f), 1));
    end
  endtask
  task t_sat;
    logic [127:0] e;
    logic [8:0] t;
    for (int j = 0; j < 16; j++) begin
      t = {1'b0, a[8*j +: 8]} - {1'b0, b[8*j +: 8]};
      e[8*j +: 8] = (!t[8] && t[7]) ? 8'h7F : (t[8] && !t[7]) ? 8'h80 : t[7:0];
    end
    issue(r3({`OPF_SUBSUU, `FMT_B}, `MINOR_3R_SAT), 3'h4);
    chk_data(result_data, e);
  endtask
  task t_shf;
    for (int f = 0; f < 4; f++) begin
      issue(r3({`OPF_SHF, 2'(f)}, `MINOR_3R_SHF), 3'h4);
      chk_data(result_data, exp_shf(2'(f)));
    end
    @(negedge core_clk);
    chk_data(rf_data, exp_shf(2'h3));
  endtask
  task t_xor;
    issue(r3(`OPF_XOR_V, `MINOR_VEC), 3'h4);
    chk_data(result_data, a ^ b);
    issue({`MAJOR_OP, `MAJOR_XORI, 8'hA5, 10'h043, `MINOR_BYTE_IMM},
      3'h4);
    chk_data(result_data, a ^ {16{8'hA5}});
  endtask
  task t_exc;
    logic [127:0] held;
    held = result_data;
    ext_present = 0;
    issue(r3({`OPF_SUB, `FMT_B}, `MINOR_3R_SUB), 3'h2);
    ext_present = 1;
    ext_enabled = 0;
    issue(r3({`OPF_SUB, `FMT_B}, `MINOR_3R_SUB), 3'h1);
    ext_enabled = 1;
    issue(r3({`OPF_SUB, `FMT_B}, 6'h3F), 3'h2);
    chk_data(result_data, held);
  endtask
  task end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    end_of_test;
  end
  initial begin
    repeat (16) @(negedge core_clk);
    reset = 0;
    t_sub_all;
    t_sat;
    t_shf;
    t_xor;
    t_exc;
    end_of_test;
  end
endmodule
`default_nettype wire

/* File: test/vec_alu_chk_sva.sv */
// port checker for the vector datapath
// assumes one clock, async active-high reset
`timescale 1ns/1ns
`default_nettype none
`include "vec_alu_map.vh"
module vec_alu_chk #(parameter VLEN = 128) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // issue side
  input wire logic issue_valid,
  input wire logic [31:0] instr,
  input wire logic ext_present,
  input wire logic ext_enabled,
  input wire logic [VLEN-1:0] first_source_vector_reg,
  input wire logic [VLEN-1:0] second_source_vector_reg,
  input wire logic [VLEN-1:0] dest_vector_reg,
  // result side
  input wire logic result_valid,
  input wire logic [4:0] result_index,
  input wire logic [VLEN-1:0] result_data,
  input wire logic reserved_instr_exc,
  input wire logic ext_disabled_exc
);
  // ****************
  // properties
  // ****************
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire logic [2:0] ans = {result_valid, reserved_instr_exc, ext_disabled_exc};
  wire logic [VLEN-1:0] a = first_source_vector_reg;
  wire logic [VLEN-1:0] b = second_source_vector_reg;
  sequence run_op(f, m);
    issue_valid && ext_present && ext_enabled &&
      instr[31:26] == `MAJOR_OP && instr[25:21] == f && instr[5:0] == m;
  endsequence
  one_answer_a: assert property (issue_valid |=> $onehot(ans))
    else $error("not exactly one answer");
  idle_quiet_a: assert property (!issue_valid |=> ans == 3'h0)
    else $error("answer without issue");
  dest_index_a: assert property (result_valid |->
    result_index == $past(instr[10:6])) else $error("bad index");
  idle_hold_a: assert property (!issue_valid |=> $stable(result_data))
    else $error("result changed when idle");
  sub_lane_a: assert property (run_op({`OPF_SUB, `FMT_D},
    `MINOR_3R_SUB) |=> result_data[63:0] == $past(a[63:0] - b[63:0]))
    else $error("subtract wrong");
  imm_sub_a: assert property (run_op({`OPF_SUB, `FMT_D},
    `MINOR_I5_SUB) |=> result_data[63:0] == $past(a[63:0] - instr[20:16]))
    else $error("immediate subtract wrong");
  vec_xor_a: assert property (run_op(`OPF_XOR_V, `MINOR_VEC)
    |=> result_data == $past(a ^ b)) else $error("xor wrong");
  byte_xor_a: assert property (issue_valid && ext_present &&
    ext_enabled && instr[31:26] == `MAJOR_OP && instr[25:24] == `MAJOR_XORI
    && instr[5:0] == `MINOR_BYTE_IMM |=> result_data ==
    $past(a ^ {(VLEN/8){instr[23:16]}})) else $error("byte xor wrong");
  no_ext_a: assert property (issue_valid && !ext_present
    |=> reserved_instr_exc) else $error("absent not refused");
  ext_off_a: assert property (issue_valid && ext_present &&
    !ext_enabled && instr[31:23] == {`MAJOR_OP, `OPF_SUB} &&
    instr[5:0] == `MINOR_3R_SUB
    |=> ext_disabled_exc) else $error("disabled not refused");
endmodule
bind vec_alu vec_alu_chk #(.VLEN(VLEN)) i_chk (.core_clk(core_clk),
  .reset(reset), .issue_valid(issue_valid), .instr(instr),
  .ext_present(ext_present), .ext_enabled(ext_enabled),
  .first_source_vector_reg(first_source_vector_reg),
  .second_source_vector_reg(second_source_vector_reg),
  .dest_vector_reg(dest_vector_reg), .result_valid(result_valid),
  .result_index(result_index), .result_data(result_data),
  .reserved_instr_exc(reserved_instr_exc),
  .ext_disabled_exc(ext_disabled_exc));
`default_nettype wire

/* File: test/vreg_file.sv */
// register file model taking the datapath's write-back
// assumes a one-cycle write strobe sampled on the rising edge
`timescale 1ns/1ns
`default_nettype none
module vreg_file #(parameter VLEN = 128) (
  // write-back
  input wire logic core_clk,
  input wire logic wr_en,
  input wire logic [4:0] wr_index,
  input wire logic [VLEN-1:0] wr_data,
  // readback
  input wire logic [4:0] rd_index,
  output logic [VLEN-1:0] rd_data
);
  // ****************
  // storage
  // ****************
  logic [VLEN-1:0] regs [0:31];
  always @(posedge core_clk) if (wr_en) regs[wr_index] <= wr_data;
  assign rd_data = regs[rd_index];
endmodule
`default_nettype wire
